// File: can_buf_count.sv
// decodes the buffer count field into a number of buffers
// accepts any field value: the reserved value 111 decodes to 4 buffers with reserved set
`timescale 1ns/1ps
`default_nettype none
module can_buf_count
	import can_buf_pkg::*;
(
	input  wire logic [2:0] sel,
	output logic      [5:0] count,
	output logic            reserved
);
	always_comb
	begin
		reserved = 1'b0;
		unique case (buf_count_t'(sel))
			CNT_4:    count = 6'h04;
			CNT_6:    count = 6'h06;
			CNT_8:    count = 6'h08;
			CNT_12:   count = 6'h0C;
			CNT_16:   count = 6'h10;
			CNT_24:   count = 6'h18;
			CNT_32:   count = 6'h20;
			CNT_RSVD:
			begin
				count    = 6'h04;
				reserved = 1'b1;
			end
		endcase
	end
endmodule // can_buf_count
`default_nettype wire

// File: can_buf_pkg.sv
// constants and carrier types for the fifo control and message buffer words
// assumes a 16-bit register port clocked by REF_CLK
// Notes on behaviour
// - buffer_count_select at bits 15:13 picks 4,6,8,12,16,24,32 buffers; 111 is reserved.
// - fifo_start_index at bits 4:0 names the first fifo buffer, all ones is buffer 31.
// - bits 12:5 of fifo_control read as zero and ignore writes.
// - word 4 holds byte 2 low and byte 3 high, read/write, undefined at power-on.
// - word 5 holds byte 4 low and byte 5 high.
// - word 6 holds byte 6 low and byte 7 high.
// - on a received frame, word 7 bits 12:8 take the accepting filter number.
// - the filter-hit field is written only for receive buffers, never for transmit.
package can_buf_pkg;

	localparam int NUM_BUF = 32;
	localparam int IDX_W   = 5;

	// address: bits 6:2 buffer index, bits 1:0 word select; only 8'h80 picks control, other bit 7 addresses read zero
	localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h80;
	localparam logic [1:0] WSEL_WORD4        = 2'h0;
	localparam logic [1:0] WSEL_WORD5        = 2'h1;
	localparam logic [1:0] WSEL_WORD6        = 2'h2;
	localparam logic [1:0] WSEL_WORD7        = 2'h3;

	localparam int CNT_MSB   = 15;
	localparam int CNT_LSB   = 13;
	localparam int START_MSB = 4;
	localparam int HIT_MSB   = 12;
	localparam int HIT_LSB   = 8;

	localparam logic [2:0]  CNT_RESET   = 3'h0;
	localparam logic [4:0]  START_RESET = 5'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;

	typedef enum logic [2:0] {
		CNT_4, CNT_6, CNT_8, CNT_12, CNT_16, CNT_24, CNT_32, CNT_RSVD
	} buf_count_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic             valid;
		logic [IDX_W-1:0] buffer;
		logic [7:0]       b2, b3, b4, b5, b6, b7;
		logic [4:0]       filter;
		logic             is_rx;
	} rx_store_t;

endpackage

// File: can_buf_regs.sv
// fifo control register and the message buffer ram for words 4 to 7
// assumes the protocol engine delivers one store request per received frame
`timescale 1ns/1ps
`default_nettype none
module can_buf_regs
	import can_buf_pkg::*;
(
	input  wire logic                   REF_CLK,
	input  wire logic                   RESETN,
	input  wire logic [7:0]             ADDR,
	input  wire logic [15:0]            WDATA,
	input  wire logic                   WR,
	input  wire logic                   RD,
	output logic      [15:0]            RDATA,
	input  wire can_buf_pkg::rx_store_t STORE,
	output logic      [5:0]             BUF_COUNT,
	output logic      [4:0]             FIFO_START,
	output logic                        COUNT_RESERVED
);
	import can_buf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge REF_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fifo control
	logic [2:0]  buffer_count_select;
	logic [4:0]  fifo_start_index;
	logic        ctl_hit;
	logic [4:0]  bidx;
	logic [1:0]  wsel;

	assign ctl_hit = (ADDR == ADDR_FIFO_CONTROL);
	assign bidx    = ADDR[6:2];
	assign wsel    = ADDR[1:0];

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			buffer_count_select <= CNT_RESET;
			fifo_start_index    <= START_RESET;
		end
		else if (WR && ctl_hit)
		begin
			buffer_count_select <= WDATA[CNT_MSB:CNT_LSB];
			fifo_start_index    <= WDATA[START_MSB:0];
		end
	end

	can_buf_count u_count (
		.sel      (buffer_count_select),
		.count    (BUF_COUNT),
		.reserved (COUNT_RESERVED)
	);

	assign FIFO_START = fifo_start_index;

	////////////////////////////////////////////////////////////////////////
	// message buffer words, no reset: contents undefined at power-on
	logic [15:0] word4 [NUM_BUF];
	logic [15:0] word5 [NUM_BUF];
	logic [15:0] word6 [NUM_BUF];
	logic [4:0]  hit   [NUM_BUF];
	logic        sw_wr;

	assign sw_wr = WR && !ADDR[7];

	// a software write to a word wins over a store to that word of any buffer; the engine
	// writes a word only in cycles with no software write to that word
	always_ff @(posedge REF_CLK)
	begin
		if (sw_wr && wsel == WSEL_WORD4)
			word4[bidx] <= WDATA;
		else if (STORE.valid)
			word4[STORE.buffer] <= {STORE.b3, STORE.b2};
	end

	always_ff @(posedge REF_CLK)
	begin
		if (sw_wr && wsel == WSEL_WORD5)
			word5[bidx] <= WDATA;
		else if (STORE.valid)
			word5[STORE.buffer] <= {STORE.b5, STORE.b4};
	end

	always_ff @(posedge REF_CLK)
	begin
		if (sw_wr && wsel == WSEL_WORD6)
			word6[bidx] <= WDATA;
		else if (STORE.valid)
			word6[STORE.buffer] <= {STORE.b7, STORE.b6};
	end

	always_ff @(posedge REF_CLK)
	begin
		if (sw_wr && wsel == WSEL_WORD7)
			hit[bidx] <= WDATA[HIT_MSB:HIT_LSB];
		else if (STORE.valid && STORE.is_rx)
			hit[STORE.buffer] <= STORE.filter;
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe
	logic [15:0] next_rdata;

	always_comb
	begin
		next_rdata = WORD_RESET;
		if (ctl_hit)
		begin
			next_rdata[CNT_MSB:CNT_LSB] = buffer_count_select;
			next_rdata[START_MSB:0]     = fifo_start_index;
		end
		else if (!ADDR[7])
		begin
			unique case (wsel)
				WSEL_WORD4: next_rdata = word4[bidx];
				WSEL_WORD5: next_rdata = word5[bidx];
				WSEL_WORD6: next_rdata = word6[bidx];
				WSEL_WORD7: next_rdata[HIT_MSB:HIT_LSB] = hit[bidx];
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n)
	begin
		if (!rst_n)
			RDATA <= WORD_RESET;
		else if (RD)
			RDATA <= next_rdata;
		else
			RDATA <= WORD_RESET;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_ctl_read;
		@(posedge REF_CLK) disable iff (!rst_n)
		(RD && ctl_hit) |=> (RDATA[12:5] == 8'h00 &&
			RDATA[4:0] == $past(fifo_start_index));
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("ctl read bad");

	property p_ctl_write;
		@(posedge REF_CLK) disable iff (!rst_n)
		(WR && ctl_hit) |=> (buffer_count_select == $past(WDATA[15:13]) &&
			fifo_start_index == $past(WDATA[4:0]));
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("ctl write bad");

	property p_count32;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == 3'h6) |-> (BUF_COUNT == 6'h20);
	endproperty
	a_count32: assert property (p_count32) else $error("count 32 bad");

	property p_count24;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == 3'h5) |-> (BUF_COUNT == 6'h18 &&
			!COUNT_RESERVED);
	endproperty
	a_count24: assert property (p_count24) else $error("count 24 bad");

	property p_store_hit;
		@(posedge REF_CLK) disable iff (!rst_n)
		(STORE.valid && STORE.is_rx && !(WR && !ADDR[7]))
		##1 (RD && !ADDR[7] && ADDR[1:0] == 2'h3 &&
			ADDR[6:2] == $past(STORE.buffer))
		|=> (RDATA[12:8] == $past(STORE.filter, 2));
	endproperty
	a_store_hit: assert property (p_store_hit) else $error("hit bad");

	property p_store_w4;
		@(posedge REF_CLK) disable iff (!rst_n)
		(STORE.valid && !(WR && !ADDR[7]))
		##1 (RD && !ADDR[7] && ADDR[1:0] == 2'h0 &&
			ADDR[6:2] == $past(STORE.buffer))
		|=> (RDATA == {$past(STORE.b3, 2), $past(STORE.b2, 2)});
	endproperty
	a_store_w4: assert property (p_store_w4) else $error("word4 bad");

	property p_store_w5;
		@(posedge REF_CLK) disable iff (!rst_n)
		(STORE.valid && !(WR && !ADDR[7]))
		##1 (RD && !ADDR[7] && ADDR[1:0] == 2'h1 &&
			ADDR[6:2] == $past(STORE.buffer))
		|=> (RDATA == {$past(STORE.b5, 2), $past(STORE.b4, 2)});
	endproperty
	a_store_w5: assert property (p_store_w5) else $error("word5 bad");

	property p_store_w6;
		@(posedge REF_CLK) disable iff (!rst_n)
		(STORE.valid && !(WR && !ADDR[7]))
		##1 (RD && !ADDR[7] && ADDR[1:0] == 2'h2 &&
			ADDR[6:2] == $past(STORE.buffer))
		|=> (RDATA == {$past(STORE.b7, 2), $past(STORE.b6, 2)});
	endproperty
	a_store_w6: assert property (p_store_w6) else $error("word6 bad");

	property p_tx_keep;
		@(posedge REF_CLK) disable iff (!rst_n)
		(STORE.valid && !STORE.is_rx && !(WR && !ADDR[7]))
		|=> (hit[$past(STORE.buffer)] == $past(hit[STORE.buffer]));
	endproperty
	a_tx_keep: assert property (p_tx_keep) else $error("tx hit written");

	property p_idle_rdata;
		@(posedge REF_CLK) disable iff (!rst_n)
		!RD |=> (RDATA == 16'h0000);
	endproperty
	a_idle_rdata: assert property (p_idle_rdata) else $error("rdata held");

	////////////////////////////////////////////////////////////////////////
	// count decode checks, one per field value except 24 and 32
	property p_count4;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == CNT_4) |-> (BUF_COUNT == 6'h04);
	endproperty
	a_count4: assert property (p_count4) else $error("count 4 bad");

	property p_count6;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == CNT_6) |-> (BUF_COUNT == 6'h06);
	endproperty
	a_count6: assert property (p_count6) else $error("count 6 bad");

	property p_count8;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == CNT_8) |-> (BUF_COUNT == 6'h08);
	endproperty
	a_count8: assert property (p_count8) else $error("count 8 bad");

	property p_count12;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == CNT_12) |-> (BUF_COUNT == 6'h0C);
	endproperty
	a_count12: assert property (p_count12) else $error("count 12 bad");

	property p_count16;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == CNT_16) |-> (BUF_COUNT == 6'h10);
	endproperty
	a_count16: assert property (p_count16) else $error("count 16 bad");

	property p_rsvd;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select == CNT_RSVD) |-> (COUNT_RESERVED &&
			BUF_COUNT == 6'h04);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bad");

	property p_not_rsvd;
		@(posedge REF_CLK) disable iff (!rst_n)
		(buffer_count_select != CNT_RSVD) |-> !COUNT_RESERVED;
	endproperty
	a_not_rsvd: assert property (p_not_rsvd) else $error("flag bad");

	////////////////////////////////////////////////////////////////////////
	// control and read port checks
	property p_ctl_hold;
		@(posedge REF_CLK) disable iff (!rst_n)
		!(WR && ctl_hit) |=> ($stable(buffer_count_select) &&
			$stable(fifo_start_index));
	endproperty
	a_ctl_hold: assert property (p_ctl_hold) else $error("ctl moved");

	property p_ctl_count;
		@(posedge REF_CLK) disable iff (!rst_n)
		(RD && ctl_hit) |=> (RDATA[CNT_MSB:CNT_LSB] ==
			$past(buffer_count_select));
	endproperty
	a_ctl_count: assert property (p_ctl_count) else $error("count rd");

	property p_other_zero;
		@(posedge REF_CLK) disable iff (!rst_n)
		(RD && ADDR[7] && !ctl_hit) |=> (RDATA == WORD_RESET);
	endproperty
	a_other_zero: assert property (p_other_zero) else $error("hole");

	property p_w7_zero;
		@(posedge REF_CLK) disable iff (!rst_n)
		(RD && !ADDR[7] && wsel == WSEL_WORD7)
		|=> (RDATA[15:13] == 3'h0 && RDATA[7:0] == 8'h00);
	endproperty
	a_w7_zero: assert property (p_w7_zero) else $error("word7 pad");

	////////////////////////////////////////////////////////////////////////
	// write, a quiet cycle, then a read of the same word
	property p_sw_w4;
		@(posedge REF_CLK) disable iff (!rst_n)
		(sw_wr && wsel == WSEL_WORD4) ##1 (!WR && !STORE.valid)
		##1 (RD && ADDR == $past(ADDR, 2))
		|=> (RDATA == $past(WDATA, 3));
	endproperty
	a_sw_w4: assert property (p_sw_w4) else $error("word4 wr bad");

	property p_sw_w5;
		@(posedge REF_CLK) disable iff (!rst_n)
		(sw_wr && wsel == WSEL_WORD5) ##1 (!WR && !STORE.valid)
		##1 (RD && ADDR == $past(ADDR, 2))
		|=> (RDATA == $past(WDATA, 3));
	endproperty
	a_sw_w5: assert property (p_sw_w5) else $error("word5 wr bad");

	property p_sw_w6;
		@(posedge REF_CLK) disable iff (!rst_n)
		(sw_wr && wsel == WSEL_WORD6) ##1 (!WR && !STORE.valid)
		##1 (RD && ADDR == $past(ADDR, 2))
		|=> (RDATA == $past(WDATA, 3));
	endproperty
	a_sw_w6: assert property (p_sw_w6) else $error("word6 wr bad");

	property p_sw_w7;
		@(posedge REF_CLK) disable iff (!rst_n)
		(sw_wr && wsel == WSEL_WORD7) ##1 (!WR && !STORE.valid)
		##1 (RD && ADDR == $past(ADDR, 2))
		|=> (RDATA[HIT_MSB:HIT_LSB] == $past(WDATA[HIT_MSB:HIT_LSB], 3));
	endproperty
	a_sw_w7: assert property (p_sw_w7) else $error("word7 wr bad");

	// a receive store the software leaves alone must show in hit the next cycle
	property p_rx_hit;
		@(posedge REF_CLK) disable iff (!rst_n)
		(STORE.valid && STORE.is_rx && !(sw_wr && wsel == WSEL_WORD7))
		|=> (hit[$past(STORE.buffer)] == $past(STORE.filter));
	endproperty
	a_rx_hit: assert property (p_rx_hit) else $error("hit not kept");

	////////////////////////////////////////////////////////////////////////
	// covers
	c_ctl_rw:   cover property (@(posedge REF_CLK)
		(WR && ctl_hit) ##2 (RD && ctl_hit));
	c_rx_store: cover property (@(posedge REF_CLK) STORE.valid && STORE.is_rx);
	c_tx_store: cover property (@(posedge REF_CLK) STORE.valid && !STORE.is_rx);
	c_rsvd:     cover property (@(posedge REF_CLK) COUNT_RESERVED);
	c_st_rd:    cover property (@(posedge REF_CLK) STORE.valid ##1 RD);

endmodule // can_buf_regs
`default_nettype wire

// File: can_engine_model.sv
// protocol engine stand-in: hands frames to the buffer ram on request
// assumes the clock of the register block; one store per call
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
	import can_buf_pkg::*;
(
	input  wire logic             REF_CLK,
	output var  can_buf_pkg::rx_store_t STORE
);
	import can_buf_pkg::*;
	initial STORE = '0;
	// one-cycle pulse; fields scrambled after so stale data never looks valid
	task automatic store(input logic [4:0] b, f, input logic rx,
		input logic [47:0] d);
	begin
		@(posedge REF_CLK);
		STORE <= rx_store_t'({1'b1, b, d, f, rx});
		@(posedge REF_CLK);
		STORE <= rx_store_t'({1'b0, ~STORE[58:0]});
	end
	endtask
endmodule // can_engine_model
`default_nettype wire

// File: test_can_buf_regs.sv
// self-checking bench for fifo control and buffer words 4 to 7
// assumes the engine model in its own file drives the store port
`timescale 1ns/1ps
`default_nettype none
module test_can_buf_regs;
	import can_buf_pkg::*;
	logic        REF_CLK = 1'b0;
	logic        RESETN  = 1'b0;
	logic [7:0]  ADDR    = 8'h00;
	logic [15:0] WDATA   = 16'h0000;
	logic        WR      = 1'b0;
	logic        RD      = 1'b0;
	logic [15:0] RDATA;
	logic [5:0]  BUF_COUNT;
	logic [4:0]  FIFO_START;
	logic        COUNT_RESERVED;
	rx_store_t   STORE;
	int          miscompares = 0;
	int          n_checks    = 0;
	logic [5:0]  cnt_tab [8] = '{6'h04, 6'h06, 6'h08, 6'h0C,
		6'h10, 6'h18, 6'h20, 6'h04};
	logic [2:0]  sel;
	logic [4:0]  idx;
	////////////////////////////////////////////////////////////////
	can_buf_regs can_buf_regs_i (.REF_CLK(REF_CLK), .RESETN(RESETN),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.STORE(STORE), .BUF_COUNT(BUF_COUNT), .FIFO_START(FIFO_START),
		.COUNT_RESERVED(COUNT_RESERVED));
	can_engine_model can_engine_model_i (.REF_CLK(REF_CLK), .STORE(STORE));
	initial
	begin
		forever #4 REF_CLK = ~REF_CLK;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
	begin
		@(posedge REF_CLK);
		ADDR <= a; WDATA <= d; WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
		#1;
	end
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
	begin
		@(posedge REF_CLK);
		ADDR <= a; RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, exp);
	end
	endtask
	// engine store, then a read of that buffer in the very next cycle
	task automatic sr(input logic [4:0] b, f, input logic rx,
		input logic [47:0] d, input logic [1:0] w, input logic [15:0] exp);
	begin
		fork
			can_engine_model_i.store(b, f, rx, d);
			begin
				@(posedge REF_CLK);
				rd(ba(b, w), exp);
			end
		join
	end
	endtask
	function automatic logic [7:0] ba(input logic [4:0] b,
		input logic [1:0] w);
		return {1'b0, b, w};
	endfunction
	task automatic close_out;
	begin
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#50000;
		miscompares++;
		close_out();
	end
	initial
	begin
		repeat (12) @(posedge REF_CLK);
		RESETN <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		rd(ADDR_FIFO_CONTROL, 16'h0000);
		chk({10'h000, BUF_COUNT}, 16'h0004);
		chk({11'h000, FIFO_START}, 16'h0000);
		for (int s = 0; s < 8; s++)
		begin
			sel = 3'(s);
			idx = 5'h1F ^ {2'h0, sel};
			wr(ADDR_FIFO_CONTROL, {sel, 8'hFF, idx});
			chk({10'h000, BUF_COUNT}, {10'h000, cnt_tab[s]});
			chk({15'h0000, COUNT_RESERVED}, {15'h0000, sel == 3'h7});
			chk({11'h000, FIFO_START}, {11'h000, idx});
			rd(ADDR_FIFO_CONTROL, {sel, 8'h00, idx});
		end
		wr(8'h81, 16'hFFFF);
		rd(8'h81, 16'h0000);
		rd(ADDR_FIFO_CONTROL, 16'hE018);
		wr(ba(5'h05, WSEL_WORD4), 16'hA1B2);
		rd(ba(5'h05, WSEL_WORD4), 16'hA1B2);
		wr(ba(5'h05, WSEL_WORD5), 16'hC3D4);
		rd(ba(5'h05, WSEL_WORD5), 16'hC3D4);
		wr(ba(5'h05, WSEL_WORD6), 16'hE5F6);
		rd(ba(5'h05, WSEL_WORD6), 16'hE5F6);
		wr(ba(5'h05, WSEL_WORD7), 16'hFFFF);
		rd(ba(5'h05, WSEL_WORD7), 16'h1F00);
		rd(ba(5'h05, WSEL_WORD4), 16'hA1B2);
		sr(5'h03, 5'h05, 1'b1, 48'h112233445566, WSEL_WORD4, 16'h2211);
		sr(5'h03, 5'h05, 1'b1, 48'h112233445566, WSEL_WORD5, 16'h4433);
		sr(5'h03, 5'h05, 1'b1, 48'h112233445566, WSEL_WORD6, 16'h6655);
		sr(5'h03, 5'h05, 1'b1, 48'h112233445566, WSEL_WORD7, 16'h0500);
		// transmit buffer: payload lands, filter field untouched
		sr(5'h03, 5'h09, 1'b0, 48'h778899AABBCC, WSEL_WORD4, 16'h8877);
		rd(ba(5'h03, WSEL_WORD7), 16'h0500);
		sr(5'h1F, 5'h1F, 1'b1, 48'h0102030405FE, WSEL_WORD6, 16'hFE05);
		rd(ba(5'h1F, WSEL_WORD7), 16'h1F00);
		close_out();
	end
endmodule // test_can_buf_regs
`default_nettype wire
